// ===== verilog/aal_pkg.sv
// What this block does
// RULE1: add-with-carry stores dst plus src plus carry; sets Z,C,N,V,H in one cycle.
// RULE2: minus_immediate stores dst minus constant; sets Z,C,N,V,H in one cycle.
// RULE3: minus_with_borrow stores dst minus src minus carry; sets all five flags, one cycle.
// RULE4: minus_imm_with_borrow stores dst minus constant minus carry; five flags, one cycle.
// RULE5: conjunction_imm writes dst AND constant; only Z,N,V change, C and H kept.
// RULE6: disjunction_imm writes dst OR constant in one cycle; only Z,N,V change.
// RULE7: set_mask_bits ORs the mask into dst in one cycle; only Z,N,V change.
// RULE8: clear_mask_bits ANDs dst with all-ones minus mask; only Z,N,V change.
// RULE9: zero_sign_test ANDs dst with itself, value unchanged; Z,N,V updated in one cycle.
// RULE10: flags not affected by an executed operation keep their previous value.
package aal_pkg;
  localparam int DATA_W = 8;

  typedef logic [DATA_W-1:0] aal_byte_t;

  typedef enum logic [3:0] {
    OP_ADD,
    OP_ADD_CARRY,
    OP_SUB,
    OP_MINUS_IMMEDIATE,
    OP_MINUS_WITH_BORROW,
    OP_MINUS_IMM_WITH_BORROW,
    OP_AND,
    OP_CONJUNCTION_IMM,
    OP_OR,
    OP_DISJUNCTION_IMM,
    OP_XOR,
    OP_SET_MASK_BITS,
    OP_CLEAR_MASK_BITS,
    OP_ZERO_SIGN_TEST
  } aal_op_e;

  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;

  localparam aal_byte_t FLAGS_RESET   = 8'h00;
  localparam aal_byte_t FLAGS_WR_MASK = 8'h3f;
  localparam aal_byte_t ALL_ONES      = 8'hff;
  localparam aal_byte_t RESULT_RESET  = 8'h00;

  // register byte offsets on the control bus
  localparam logic [31:0] REG_FLAGS_OFS  = 32'h0000_0000;
  localparam logic [31:0] REG_RESULT_OFS = 32'h0000_0004;

  localparam logic [1:0] SEL_NONE   = 2'h0;
  localparam logic [1:0] SEL_FLAGS  = 2'h1;
  localparam logic [1:0] SEL_RESULT = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== verilog/aal_addsub.sv
`timescale 1ns/10ps
// shared adder for add and subtract forms; subtract is a + ~b + ~borrow
module aal_addsub (
  input  wire logic [7:0] i_a,
  input  wire logic [7:0] i_b,
  input  wire logic       i_cin,
  input  wire logic       i_sub,
  output logic      [7:0] o_sum,
  output logic            o_carry,
  output logic            o_half,
  output logic            o_ovf
);
  logic [7:0] b_eff;
  logic       c_eff;
  logic [4:0] low;
  logic [8:0] full;

  always_comb begin
    b_eff   = i_sub ? ~i_b : i_b;
    c_eff   = i_sub ? ~i_cin : i_cin;
    low     = {1'b0, i_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
    full    = {1'b0, i_a} + {1'b0, b_eff} + {8'h00, c_eff};
    o_sum   = full[7:0];
    // carry out of an inverted subtract is the complement of the borrow
    o_carry = full[8] ^ i_sub;
    o_half  = low[4] ^ i_sub;
    o_ovf   = (i_a[7] == b_eff[7]) && (full[7] != i_a[7]);
  end
endmodule

// ===== verilog/aal_alu.sv
`timescale 1ns/10ps
module aal_alu
  import aal_pkg::*;
#(
  parameter int AXI_AW = 8
) (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_arst_n,
  input  wire logic                  i_op_valid,
  input  wire aal_pkg::aal_op_e      i_op,
  input  wire aal_pkg::aal_byte_t    i_dst,
  input  wire aal_pkg::aal_byte_t    i_src_operand,
  output aal_pkg::aal_byte_t         o_result,
  output logic                       o_result_valid,
  output aal_pkg::aal_byte_t         o_flags,
  input  wire logic                  i_s_axi_awvalid,
  output logic                       o_s_axi_awready,
  input  wire logic [AXI_AW-1:0]     i_s_axi_awaddr,
  input  wire logic                  i_s_axi_wvalid,
  output logic                       o_s_axi_wready,
  input  wire logic [31:0]           i_s_axi_wdata,
  input  wire logic [3:0]            i_s_axi_wstrb,
  output logic                       o_s_axi_bvalid,
  input  wire logic                  i_s_axi_bready,
  output logic [1:0]                 o_s_axi_bresp,
  input  wire logic                  i_s_axi_arvalid,
  output logic                       o_s_axi_arready,
  input  wire logic [AXI_AW-1:0]     i_s_axi_araddr,
  output logic                       o_s_axi_rvalid,
  input  wire logic                  i_s_axi_rready,
  output logic [31:0]                o_s_axi_rdata,
  output logic [1:0]                 o_s_axi_rresp
);
  import aal_pkg::*;

  if (AXI_AW < 3 || AXI_AW > 32) begin : g_bad_aw
    $error("AXI_AW must lie between 3 and 32");
  end

  typedef struct packed {
    aal_byte_t         result;
    logic              res_valid;
    aal_byte_t         flags;
    logic              awready;
    logic              wready;
    logic              aw_got;
    logic [AXI_AW-1:0] aw_addr;
    logic              w_got;
    aal_byte_t         w_data;
    logic              w_strb0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } aal_state_s;

  aal_state_s st;
  aal_state_s next_st;

  logic      as_sub;
  logic      as_cin;
  aal_byte_t as_sum;
  logic      as_c;
  logic      as_h;
  logic      as_v;
  logic      wr_fire;

  function automatic logic [1:0] reg_sel(input logic [AXI_AW-1:0] addr);
    if (addr == AXI_AW'(REG_FLAGS_OFS)) begin
      return SEL_FLAGS;
    end
    if (addr == AXI_AW'(REG_RESULT_OFS)) begin
      return SEL_RESULT;
    end
    return SEL_NONE;
  endfunction

  // logic forms: V cleared, N from the top bit; C, H and S untouched
  function automatic aal_byte_t logic_flags(input aal_byte_t f, input aal_byte_t r);
    aal_byte_t o;
    o         = f;
    o[FLAG_Z] = (r == '0);
    o[FLAG_N] = r[DATA_W-1];
    o[FLAG_V] = 1'b0;
    return o;
  endfunction

  function automatic aal_byte_t arith_flags(input aal_byte_t f, input aal_byte_t r,
                                            input logic c, input logic h, input logic v);
    aal_byte_t o;
    o         = f;
    o[FLAG_Z] = (r == '0);
    // S is affected by no form here, so only a bus write moves it
    o[FLAG_N] = r[DATA_W-1];
    o[FLAG_V] = v;
    o[FLAG_C] = c;
    o[FLAG_H] = h;
    return o;
  endfunction

  always_comb begin
    as_sub = (i_op == OP_SUB) || (i_op == OP_MINUS_IMMEDIATE) ||
             (i_op == OP_MINUS_WITH_BORROW) || (i_op == OP_MINUS_IMM_WITH_BORROW);
    as_cin = st.flags[FLAG_C] && ((i_op == OP_ADD_CARRY) || (i_op == OP_MINUS_WITH_BORROW) ||
                                  (i_op == OP_MINUS_IMM_WITH_BORROW));
  end

  aal_addsub u_addsub (
    .i_a     (i_dst),
    .i_b     (i_src_operand),
    .i_cin   (as_cin),
    .i_sub   (as_sub),
    .o_sum   (as_sum),
    .o_carry (as_c),
    .o_half  (as_h),
    .o_ovf   (as_v)
  );

  always_comb begin
    next_st           = st;
    next_st.res_valid = 1'b0;
    wr_fire           = st.aw_got && st.w_got && !st.bvalid;

    if (i_s_axi_awvalid && st.awready) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && st.wready) begin
      next_st.w_got   = 1'b1;
      next_st.w_data  = i_s_axi_wdata[7:0];
      next_st.w_strb0 = i_s_axi_wstrb[0];
    end
    if (st.bvalid && i_s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = (reg_sel(st.aw_addr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      // software may preload flags, e.g. the carry that feeds the next borrow op
      if (reg_sel(st.aw_addr) == SEL_FLAGS && st.w_strb0) begin
        next_st.flags = st.w_data & FLAGS_WR_MASK;
      end
    end
    next_st.awready = !next_st.aw_got && !next_st.bvalid;
    next_st.wready  = !next_st.w_got && !next_st.bvalid;

    if (st.rvalid && i_s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (i_s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = RESP_OKAY;
      case (reg_sel(i_s_axi_araddr))
        SEL_FLAGS: begin
          next_st.rdata = {24'h000000, st.flags};
        end
        SEL_RESULT: begin
          next_st.rdata = {24'h000000, st.result};
        end
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end
    next_st.arready = !next_st.rvalid;

    // an executing op owns the flags: a bus write landing in the same cycle is dropped
    if (i_op_valid) begin
      next_st.res_valid = 1'b1;
      next_st.flags     = st.flags;
      case (i_op)
        OP_ADD, OP_ADD_CARRY, OP_SUB, OP_MINUS_IMMEDIATE, OP_MINUS_WITH_BORROW,
        OP_MINUS_IMM_WITH_BORROW: begin
          next_st.result = as_sum; // RULE1 RULE2 RULE3 RULE4
          next_st.flags  = arith_flags(st.flags, as_sum, as_c, as_h, as_v); // RULE1 RULE2 RULE3 RULE4
        end
        OP_AND, OP_CONJUNCTION_IMM: begin
          next_st.result = i_dst & i_src_operand; // RULE5
          next_st.flags  = logic_flags(st.flags, i_dst & i_src_operand); // RULE5 RULE10
        end
        OP_OR, OP_DISJUNCTION_IMM, OP_SET_MASK_BITS: begin
          next_st.result = i_dst | i_src_operand; // RULE6 RULE7
          next_st.flags  = logic_flags(st.flags, i_dst | i_src_operand); // RULE6 RULE7 RULE10
        end
        OP_XOR: begin
          next_st.result = i_dst ^ i_src_operand;
          next_st.flags  = logic_flags(st.flags, i_dst ^ i_src_operand);
        end
        OP_CLEAR_MASK_BITS: begin
          next_st.result = i_dst & (ALL_ONES - i_src_operand); // RULE8
          next_st.flags  = logic_flags(st.flags, i_dst & (ALL_ONES - i_src_operand)); // RULE8 RULE10
        end
        OP_ZERO_SIGN_TEST: begin
          next_st.result = i_dst & i_dst; // RULE9
          next_st.flags  = logic_flags(st.flags, i_dst); // RULE9 RULE10
        end
        default: begin
          next_st.res_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st         <= '0;
      st.result  <= RESULT_RESET;
      st.flags   <= FLAGS_RESET;
      st.awready <= 1'b1;
      st.wready  <= 1'b1;
      st.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_result        = st.result;
  assign o_result_valid  = st.res_valid;
  assign o_flags         = st.flags;
  assign o_s_axi_awready = st.awready;
  assign o_s_axi_wready  = st.wready;
  assign o_s_axi_bvalid  = st.bvalid;
  assign o_s_axi_bresp   = st.bresp;
  assign o_s_axi_arready = st.arready;
  assign o_s_axi_rvalid  = st.rvalid;
  assign o_s_axi_rdata   = st.rdata;
  assign o_s_axi_rresp   = st.rresp;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  sequence seq_exec(aal_op_e op);
    i_op_valid && (i_op == op);
  endsequence

  sequence seq_done;
    o_result_valid;
  endsequence

  AST_ADD_CARRY: assert property (seq_exec(OP_ADD_CARRY) |=> seq_done and // RULE1
    o_result == 8'($past(i_dst) + $past(i_src_operand) + 8'($past(st.flags[FLAG_C]))))
    else $error("add with carry result wrong");
  AST_MINUS_IMM: assert property (seq_exec(OP_MINUS_IMMEDIATE) |=> seq_done and // RULE2
    (o_result == 8'($past(i_dst) - $past(i_src_operand))) &&
    (o_flags[FLAG_C] == ($past(i_src_operand) > $past(i_dst))))
    else $error("subtract immediate result or carry wrong");
  AST_MINUS_BORROW: assert property (seq_exec(OP_MINUS_WITH_BORROW) |=> // RULE3
    o_result == 8'($past(i_dst) - $past(i_src_operand) - 8'($past(st.flags[FLAG_C]))))
    else $error("subtract with borrow result wrong");
  AST_MINUS_IMM_BORROW: assert property (seq_exec(OP_MINUS_IMM_WITH_BORROW) |=> // RULE4
    (o_result == 8'($past(i_dst) - $past(i_src_operand) - 8'($past(st.flags[FLAG_C])))) &&
    (o_flags[FLAG_Z] == (o_result == 8'h00)))
    else $error("immediate subtract with borrow wrong");
  AST_CONJ_KEEPS_CH: assert property (seq_exec(OP_CONJUNCTION_IMM) |=> // RULE5
    (o_result == ($past(i_dst) & $past(i_src_operand))) &&
    (o_flags[FLAG_C] == $past(o_flags[FLAG_C])) && (o_flags[FLAG_H] == $past(o_flags[FLAG_H])))
    else $error("and immediate disturbed carry or half carry");
  AST_DISJ_FLAGS: assert property (seq_exec(OP_DISJUNCTION_IMM) |=> // RULE6
    !o_flags[FLAG_V] && (o_flags[FLAG_N] == o_result[7]) &&
    (o_result == ($past(i_dst) | $past(i_src_operand))))
    else $error("or immediate flags wrong");
  AST_SET_MASK: assert property (seq_exec(OP_SET_MASK_BITS) |=> // RULE7
    o_result == ($past(i_dst) | $past(i_src_operand)))
    else $error("set mask bits result wrong");
  AST_CLEAR_MASK: assert property (seq_exec(OP_CLEAR_MASK_BITS) |=> // RULE8
    o_result == ($past(i_dst) & ~$past(i_src_operand)))
    else $error("clear mask bits result wrong");
  AST_TEST: assert property (seq_exec(OP_ZERO_SIGN_TEST) |=> // RULE9
    (o_result == $past(i_dst)) && (o_flags[FLAG_Z] == ($past(i_dst) == 8'h00)))
    else $error("zero sign test wrong");
  AST_FLAGS_HOLD: assert property (!i_op_valid && !wr_fire |=> $stable(o_flags)) // RULE10
    else $error("flags changed with no operation");
  AST_SIGN_KEPT: assert property (i_op_valid |=> $stable(o_flags[FLAG_S])) // RULE10
    else $error("an operation changed the S flag");
endmodule

// ===== test/aal_regfile_model.sv
`timescale 1ns/10ps
// stand-in for the decoder and register file: one destination byte, loaded by the bench
// or written back from the alu result; load wins so the bench can set up the next op
module aal_regfile_model (
  input  wire logic              i_sys_clk,
  input  wire logic              i_arst_n,
  input  wire logic              i_ld,
  input  wire aal_pkg::aal_byte_t i_ld_val,
  input  wire logic              i_wb,
  input  wire aal_pkg::aal_byte_t i_wb_val,
  output aal_pkg::aal_byte_t     o_dst
);
  import aal_pkg::*;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_dst <= 8'h00;
    end else if (i_ld) begin
      o_dst <= i_ld_val;
    end else if (i_wb) begin
      o_dst <= i_wb_val;
    end
  end
endmodule

// ===== test/alu_arith_logic_ops_tb_top.sv
`timescale 1ns/10ps
module alu_arith_logic_ops_tb_top;
  import aal_pkg::*;

  logic        clk = 0, rst_n = 0, opv = 0, ld = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  aal_op_e     op = OP_ADD;
  aal_byte_t   src = 8'h00, ldv = 8'h00, dst, res, flg, lst = 8'h00;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic [3:0]  ws = 4'h0;
  logic        rv, awr, wr, bv, arr, rvl;
  logic [1:0]  br, rr;
  int          n_mismatch = 0, tests_run = 0;
  aal_byte_t   corner [6] = '{8'h00, 8'hff, 8'h7f, 8'h80, 8'h0f, 8'h10};

  always #12.5 clk = ~clk;

  aal_alu u_aal_alu (
    .i_sys_clk(clk), .i_arst_n(rst_n), .i_op_valid(opv), .i_op(op), .i_dst(dst), .i_src_operand(src),
    .o_result(res), .o_result_valid(rv), .o_flags(flg),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .o_s_axi_bresp(br),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
    .o_s_axi_rvalid(rvl), .i_s_axi_rready(rry), .o_s_axi_rdata(rd), .o_s_axi_rresp(rr)
  );

  aal_regfile_model u_aal_regfile_model (
    .i_sys_clk(clk), .i_arst_n(rst_n), .i_ld(ld), .i_ld_val(ldv), .i_wb(rv), .i_wb_val(res), .o_dst(dst)
  );

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // result in [15:8], flags in [7:0]
  function automatic logic [15:0] ref_op(aal_op_e o, aal_byte_t d, aal_byte_t s, aal_byte_t f);
    logic [8:0] w;
    logic       ci, h, v, ar;
    aal_byte_t  r, nf;
    nf = f;
    w  = 9'h000;
    h  = 1'b0;
    v  = 1'b0;
    ar = (o <= OP_MINUS_IMM_WITH_BORROW);
    ci = f[FLAG_C] & (o == OP_ADD_CARRY || o == OP_MINUS_WITH_BORROW || o == OP_MINUS_IMM_WITH_BORROW);
    case (o)
      OP_ADD, OP_ADD_CARRY: begin
        w = {1'b0, d} + {1'b0, s} + 9'(ci);
        h = ({1'b0, d[3:0]} + {1'b0, s[3:0]} + 5'(ci)) > 5'h0f;
        v = (d[7] == s[7]) && (w[7] != d[7]);
      end
      OP_SUB, OP_MINUS_IMMEDIATE, OP_MINUS_WITH_BORROW, OP_MINUS_IMM_WITH_BORROW: begin
        w = {1'b0, d} - {1'b0, s} - 9'(ci);
        h = {1'b0, d[3:0]} < ({1'b0, s[3:0]} + 5'(ci));
        v = (d[7] != s[7]) && (w[7] != d[7]);
      end
      OP_AND, OP_CONJUNCTION_IMM: w[7:0] = d & s;
      OP_OR, OP_DISJUNCTION_IMM, OP_SET_MASK_BITS: w[7:0] = d | s;
      OP_XOR: w[7:0] = d ^ s;
      OP_CLEAR_MASK_BITS: w[7:0] = d & (ALL_ONES - s);
      default: w[7:0] = d;
    endcase
    r = w[7:0];
    nf[FLAG_Z] = (r == 8'h00);
    nf[FLAG_N] = r[7];
    nf[FLAG_V] = ar & v;
    if (ar) begin
      nf[FLAG_C] = w[8];
      nf[FLAG_H] = h;
    end
    return {r, nf};
  endfunction

  function automatic aal_byte_t pick();
    return ($urandom % 3 == 0) ? corner[$urandom % 6] : aal_byte_t'($urandom);
  endfunction

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic ad, wdn;
    ad  = 1'b0;
    wdn = 1'b0;
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv  <= 1'b1;
    wd  <= d;
    ws  <= s;
    bry <= 1'b1;
    while (!(ad && wdn)) begin
      @(posedge clk);
      if (awv && awr) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wr) begin
        wdn = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (!bv);
    bry <= 1'b0;
    chk(32'(br), 32'(er));
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rvl);
    rry <= 1'b0;
    chk(rd, ed);
    chk(32'(rr), 32'(er));
  endtask

  task automatic run_op(input aal_op_e o, input aal_byte_t d, input aal_byte_t s);
    logic [15:0] e;
    @(posedge clk);
    ld  <= 1'b1;
    ldv <= d;
    @(posedge clk);
    ld  <= 1'b0;
    opv <= 1'b1;
    op  <= o;
    src <= s;
    #1 e = ref_op(o, dst, s, flg);
    @(posedge clk);
    opv <= 1'b0;
    #1 chk({rv, res, flg}, {1'b1, e});
    lst = e[15:8];
    @(posedge clk);
    #1 chk(32'(rv), 32'h0);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    aal_byte_t f;
    void'($urandom(88));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk({rv, res, flg}, {1'b0, RESULT_RESET, FLAGS_RESET});
    axi_wr(REG_FLAGS_OFS[7:0], 32'h1, 4'hf, RESP_OKAY);
    run_op(OP_ADD_CARRY, 8'h0f, 8'h01);
    // every opcode with carry clear and set, on boundary operands
    for (int i = 0; i < 28; i++) begin
      axi_wr(REG_FLAGS_OFS[7:0], 32'(i % 2) | 32'h20, 4'h1, RESP_OKAY);
      run_op(aal_op_e'(i / 2), corner[i % 6], corner[(i / 2) % 6]);
    end
    for (int k = 0; k < 300; k++) begin
      f = aal_byte_t'($urandom);
      axi_wr(REG_FLAGS_OFS[7:0], 32'(f), 4'hf, RESP_OKAY);
      axi_rd(REG_FLAGS_OFS[7:0], 32'(f & FLAGS_WR_MASK), RESP_OKAY);
      run_op(aal_op_e'($urandom % 14), pick(), pick());
    end
    axi_rd(REG_RESULT_OFS[7:0], 32'(lst), RESP_OKAY);
    axi_wr(REG_RESULT_OFS[7:0], 32'h5a, 4'hf, RESP_OKAY);
    axi_rd(REG_RESULT_OFS[7:0], 32'(lst), RESP_OKAY);
    axi_wr(REG_FLAGS_OFS[7:0], 32'h2a, 4'hf, RESP_OKAY);
    axi_wr(REG_FLAGS_OFS[7:0], 32'h15, 4'he, RESP_OKAY);
    axi_rd(REG_FLAGS_OFS[7:0], 32'h2a, RESP_OKAY);
    axi_rd(8'h08, 32'h0, RESP_SLVERR);
    axi_wr(8'h0c, 32'h1, 4'hf, RESP_SLVERR);
    axi_rd(8'h02, 32'h0, RESP_SLVERR);
    // an op and a landing flags write in one cycle: the op owns the flags, the write is lost
    axi_wr(REG_FLAGS_OFS[7:0], 32'h0, 4'hf, RESP_OKAY);
    fork
      axi_wr(REG_FLAGS_OFS[7:0], 32'h3f, 4'hf, RESP_OKAY);
      run_op(OP_AND, 8'h81, 8'h80);
    join
    axi_rd(REG_FLAGS_OFS[7:0], 32'h04, RESP_OKAY);
    give_verdict();
  end
endmodule
